/* File: rtl/wpr_pkg.sv */
package wpr_pkg;
  // fixed bus addresses, no address pins on this block
  localparam logic [6:0] SLV_ADDR_STD  = 7'h2E;
  localparam logic [6:0] SLV_ADDR_ALT  = 7'h3E;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  // wiper register: power-on value is mid-scale
  localparam logic [6:0] WIPER_RST     = 7'h3F;
  // only command code zero addresses the wiper
  localparam logic [7:0] CMD_WIPER     = 8'h00;
  // byte returned when the command code did not select the wiper
  localparam logic [7:0] RD_BLANK      = 8'hFF;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK  = 7'h04,
    ST_CMD  = 7'h08,
    ST_DATA = 7'h10,
    ST_TX   = 7'h20,
    ST_MACK = 7'h40
  } wpr_state_type;

  // which byte the device is acknowledging
  typedef enum logic [3:0] {
    AK_ADDR_WR = 4'h1,
    AK_ADDR_RD = 4'h2,
    AK_CMD     = 4'h4,
    AK_DATA    = 4'h8
  } wpr_ack_type;
endpackage

/* File: rtl/wpr_slave.sv */
// Contract
// - bad command: release data, wait new start
// - slave only, seven fixed address bits
// - address 0101110, option selects 0111110
// - control byte follows start, address then direction
// - no address select inputs at all
// - general call is not acknowledged
// - start resets interface only, not wiper
// - master not-acknowledge resets interface
// - start during write acknowledge keeps the write
// - after stop, idle until next start
// - write format; device drives every acknowledge
// - data byte committed during its acknowledge
// - byte cut by start or stop is dropped
// - further data bytes each committed in turn
// - data byte MSB ignored, seven bits stored
// - non-zero command suppresses wiper write
// - read format with repeated start and read bit
// - device drives data until eight bits out
// - non-zero command never returns wiper value
// - stop ends command, repeated start keeps it
// - clock line is never held low
// - mismatched address gets not-acknowledge
// - reset loads wiper with mid-scale
`timescale 1ns/1ps
`default_nettype none

module wpr_slave #(
  parameter bit ALT_ADDR = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [6:0]      wiper_position
);
  import wpr_pkg::*;

  // address is fixed by the build option only, no pins
  localparam logic [6:0] OWN_ADDR = ALT_ADDR ? SLV_ADDR_ALT : SLV_ADDR_STD;

  // general call never matches, so it falls through to a not-acknowledge
  function automatic logic addr_hit(input logic [6:0] a);
    addr_hit = (a == OWN_ADDR) && (a != GEN_CALL_ADDR);
  endfunction

  logic [2:0]    scl_s;
  logic [2:0]    sda_s;
  logic          scl_f;
  logic          sda_f;
  logic          scl_q;
  logic          sda_q;
  logic          next_scl_f;
  logic          next_sda_f;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_evt;
  logic          stop_evt;

  wpr_state_type state;
  wpr_state_type next_state;
  wpr_ack_type   kind;
  wpr_ack_type   next_kind;
  logic [3:0]    bitcnt;
  logic [3:0]    next_bitcnt;
  logic [7:0]    shift;
  logic [7:0]    next_shift;
  logic [7:0]    tx;
  logic [7:0]    next_tx;
  logic          cmd_ok;
  logic          next_cmd_ok;
  logic          drive;
  logic          next_drive;
  logic [6:0]    next_wiper;

  // open-drain data: only ever pulls low; the clock pin has no driver
  assign sda_out        = 1'b0;
  assign sda_oe         = drive;

  // a filtered level moves only once stages two and three agree
  always_comb begin
    next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
    next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
  end

  // lines idle high, so the chain resets to one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // bus events; start and stop are data edges with the clock high
  assign scl_rise  = scl_f & ~scl_q;
  assign scl_fall  = ~scl_f & scl_q;
  assign start_evt = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_evt  = scl_f & scl_q & ~sda_q & sda_f;

  // protocol engine; transitions occur on filtered clock edges or on start and stop
  always_comb begin
    next_state  = state;
    next_kind   = kind;
    next_bitcnt = bitcnt;
    next_shift  = shift;
    next_tx     = tx;
    next_cmd_ok = cmd_ok;
    next_drive  = drive;
    next_wiper  = wiper_position;
    if (stop_evt) begin
      // stop ends any command and leaves the bus watched
      next_state  = ST_IDLE;
      next_drive  = 1'b0;
      next_cmd_ok = 1'b0;
    end else if (start_evt) begin
      // interface restarts; wiper untouched, open byte dropped
      next_state  = ST_ADDR;
      next_bitcnt = '0;
      next_drive  = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_DATA: begin
          if (scl_rise) begin
            next_shift  = {shift[6:0], sda_f};
            next_bitcnt = 4'(bitcnt + 4'h1);
          end else if (scl_fall && bitcnt == BYTE_BITS) begin
            next_bitcnt = '0;
            if (state == ST_ADDR) begin
              if (addr_hit(shift[7:1])) begin
                next_state = ST_ACK;
                next_drive = 1'b1;
                next_kind  = shift[0] ? AK_ADDR_RD : AK_ADDR_WR;
              end else begin
                next_state = ST_IDLE;
              end
            end else if (state == ST_CMD) begin
              if (shift == CMD_WIPER) begin
                next_cmd_ok = 1'b1;
                next_state  = ST_ACK;
                next_drive  = 1'b1;
                next_kind   = AK_CMD;
              end else begin
                // undefined command: go passive until a new start
                next_cmd_ok = 1'b0;
                next_state  = ST_IDLE;
              end
            end else begin
              next_state = ST_ACK;
              next_drive = 1'b1;
              next_kind  = AK_DATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_rise && kind == AK_DATA && cmd_ok) begin
            // commit in the acknowledge bit, MSB dropped
            next_wiper = shift[6:0];
          end else if (scl_fall) begin
            next_bitcnt = '0;
            if (kind == AK_ADDR_WR) begin
              next_state = ST_CMD;
              next_drive = 1'b0;
            end else if (kind == AK_ADDR_RD) begin
              // read byte: wiper with MSB zero, else all ones
              next_tx    = cmd_ok ? {1'b0, wiper_position}
                                  : RD_BLANK;
              next_state = ST_TX;
              next_drive = ~next_tx[7];
            end else begin
              next_state = ST_DATA;
              next_drive = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bitcnt = 4'(bitcnt + 4'h1);
          end else if (scl_fall) begin
            if (bitcnt == BYTE_BITS) begin
              next_state  = ST_MACK;
              next_drive  = 1'b0;
              next_bitcnt = '0;
            end else begin
              next_tx    = {tx[6:0], 1'b1};
              next_drive = ~tx[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_f) begin
            // master not-acknowledge ends the read
            next_state = ST_IDLE;
          end else if (scl_fall) begin
            // acknowledged: the same byte goes out again
            next_tx    = cmd_ok ? {1'b0, wiper_position} : RD_BLANK;
            next_state = ST_TX;
            next_drive = ~next_tx[7];
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // engine registers; wiper takes its mid-scale value at reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state          <= ST_IDLE;
      kind           <= AK_ADDR_WR;
      bitcnt         <= '0;
      shift          <= '0;
      tx             <= '0;
      cmd_ok         <= 1'b0;
      drive          <= 1'b0;
      wiper_position <= WIPER_RST;
    end else begin
      state          <= next_state;
      kind           <= next_kind;
      bitcnt         <= next_bitcnt;
      shift          <= next_shift;
      tx             <= next_tx;
      cmd_ok         <= next_cmd_ok;
      drive          <= next_drive;
      wiper_position <= next_wiper;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_data_ack;
    state == ST_ACK && kind == AK_DATA && cmd_ok && scl_rise;
  endsequence

  sequence s_addr_done;
    state == ST_ADDR && scl_fall && bitcnt == BYTE_BITS;
  endsequence

  a_stop_idle: assert property (
    stop_evt |=> state == ST_IDLE && !sda_oe && !cmd_ok)
    else $error("stop did not return the interface to idle");

  a_start_addr: assert property (
    start_evt |=> state == ST_ADDR && bitcnt == 4'h0 &&
                  $stable(wiper_position))
    else $error("start did not restart address reception");

  a_wiper_commit: assert property (
    s_data_ack |=> wiper_position == $past(shift[6:0]))
    else $error("data byte not committed in its acknowledge");

  a_wiper_hold: assert property (
    !(state == ST_ACK && kind == AK_DATA) |=> $stable(wiper_position))
    else $error("wiper changed outside a data acknowledge");

  a_cmd_gate: assert property (
    !cmd_ok |=> $stable(wiper_position))
    else $error("wiper written without a valid command code");

  a_addr_nack: assert property (
    s_addr_done ##0 !addr_hit(shift[7:1]) |=> state == ST_IDLE ##1 !sda_oe)
    else $error("foreign address was acknowledged");

  a_addr_ack: assert property (
    s_addr_done ##0 addr_hit(shift[7:1]) |=> sda_oe && state == ST_ACK)
    else $error("own address not acknowledged");

  a_mnack_reset: assert property (
    state == ST_MACK && scl_rise && sda_f |=> state == ST_IDLE && !sda_oe)
    else $error("master not-acknowledge did not reset interface");

  a_read_msb: assert property (
    state == ST_ACK && kind == AK_ADDR_RD && scl_fall
    |=> state == ST_TX && sda_oe == cmd_ok)
    else $error("first read bit wrong for command state");

  a_oe_legal: assert property (
    sda_oe |-> state inside {ST_ACK, ST_TX})
    else $error("data line driven outside acknowledge or read");
endmodule

`default_nettype wire

/* File: verification/wpr_mst.sv */
`timescale 1ns/1ps
`default_nettype none

// bus master model; scl idles high and only runs inside frames
module wpr_mst (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_bus
);
  localparam realtime Q = 31.25;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask

  // stop: sda rises while scl is high, then the bus rests
  task automatic stop();
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask

  // sda only moves while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #Q scl = 1'b1;
    #Q r = sda_bus;
    #Q scl = 1'b0;
    #Q;
  endtask

  // one byte msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(mack, ack);
  endtask

  // recovery: start, nine released bits, start, stop
  task automatic swreset();
    logic x;
    start();
    repeat (9) bit_io(1'b1, x);
    start();
    stop();
  endtask
endmodule

`default_nettype wire

/* File: verification/test_wpr_slave.sv */
`timescale 1ns/1ps
`default_nettype none

module test_wpr_slave;
  import wpr_pkg::*;
  logic       clk;
  logic       sys_rst;
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe;
  logic [6:0] wiper_position;
  wire logic  sda_bus;
  logic [7:0] q;
  logic [2:0] acks;
  logic       x;
  int         num_errors;
  int         compares;
  int         cycles;

  // open drain wire with pull-up
  assign sda_bus = sda_drv & ~(sda_oe & ~sda_out);

  wpr_slave #(.ALT_ADDR(1'b0)) wpr_slave_i (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe), .wiper_position(wiper_position));
  wpr_mst wpr_mst_i (.scl(scl), .sda_drv(sda_drv), .sda_bus(sda_bus));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // start, address with write bit, command code
  task automatic head(input logic [6:0] a, input logic [7:0] c);
    wpr_mst_i.start();
    wpr_mst_i.xfer({a, 1'b0}, 1'b1, q, acks[2]);
    wpr_mst_i.xfer(c, 1'b1, q, acks[1]);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] c, d);
    head(a, c);
    wpr_mst_i.xfer(d, 1'b1, q, acks[0]);
    wpr_mst_i.stop();
  endtask

  // single read, master refuses the data byte
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    head(a, c);
    wpr_mst_i.start();
    wpr_mst_i.xfer({a, 1'b1}, 1'b1, q, acks[0]);
    wpr_mst_i.xfer(8'hFF, 1'b1, q, x);
    wpr_mst_i.stop();
  endtask

  function automatic logic [7:0] wp();
    return {1'b0, wiper_position};
  endfunction

  // hang guard, well above the expected run of about 6500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("wiper at reset", wp(), {1'b0, WIPER_RST});
    check("pins at reset", {6'h00, sda_out, sda_oe}, 8'h00);
    repeat (6) @(posedge clk);
    wr(SLV_ADDR_STD, CMD_WIPER, 8'hD5);
    check("write acks", {5'h00, acks}, 8'h00);
    check("wiper write", wp(), 8'h55);
    rd(SLV_ADDR_STD, CMD_WIPER);
    check("read acks", {5'h00, acks}, 8'h00);
    check("read data", q, 8'h55);
    // two-byte read: master acknowledges the first byte, refuses the last
    head(SLV_ADDR_STD, CMD_WIPER);
    wpr_mst_i.start();
    wpr_mst_i.xfer({SLV_ADDR_STD, 1'b1}, 1'b1, q, x);
    wpr_mst_i.xfer(8'hFF, 1'b0, q, x);
    check("read first of two", q, 8'h55);
    wpr_mst_i.xfer(8'hFF, 1'b1, q, x);
    check("read last of two", q, 8'h55);
    wpr_mst_i.stop();
    $display("test write and read done");
    head(SLV_ADDR_STD, CMD_WIPER);
    wpr_mst_i.xfer(8'h12, 1'b1, q, x);
    check("burst first", wp(), 8'h12);
    wpr_mst_i.xfer(8'h7F, 1'b1, q, x);
    check("burst second", wp(), 8'h7F);
    repeat (4) wpr_mst_i.bit_io(1'b0, x);
    wpr_mst_i.start();
    wpr_mst_i.stop();
    check("cut by restart", wp(), 8'h7F);
    head(SLV_ADDR_STD, CMD_WIPER);
    repeat (4) wpr_mst_i.bit_io(1'b0, x);
    wpr_mst_i.stop();
    check("cut by stop", wp(), 8'h7F);
    $display("test burst and abort done");
    for (int i = 0; i < 2; i++) begin
      wr(i == 0 ? SLV_ADDR_ALT : GEN_CALL_ADDR, CMD_WIPER, 8'h01);
      check("foreign acks", {5'h00, acks}, 8'h07);
    end
    check("foreign wiper", wp(), 8'h7F);
    wr(SLV_ADDR_STD, 8'h01, 8'h00);
    check("bad cmd acks", {5'h00, acks}, 8'h03);
    check("bad cmd wiper", wp(), 8'h7F);
    rd(SLV_ADDR_STD, 8'h01);
    check("bad cmd read acks", {5'h00, acks}, 8'h02);
    check("bad cmd read", q, RD_BLANK);
    $display("test refusals done");
    wr(SLV_ADDR_STD, CMD_WIPER, 8'h00);
    head(SLV_ADDR_STD, CMD_WIPER);
    wpr_mst_i.start();
    wpr_mst_i.xfer({SLV_ADDR_STD, 1'b1}, 1'b1, q, x);
    repeat (3) wpr_mst_i.bit_io(1'b1, x);
    wpr_mst_i.swreset();
    check("wiper kept", wp(), 8'h00);
    rd(SLV_ADDR_STD, CMD_WIPER);
    check("recovered acks", {5'h00, acks}, 8'h00);
    check("recovered read", q, 8'h00);
    $display("test recovery done");
    @(posedge clk);
    #1 sys_rst = 1'b1;
    @(posedge clk);
    #1 sys_rst = 1'b0;
    check("wiper re-reset", wp(), {1'b0, WIPER_RST});
    $display("test second reset done");
    close_out();
  end
endmodule

`default_nettype wire
